// File: hdl/ecp_defs.vh
// Constants for the EEPROM configuration and protection block
`ifndef ECP_DEFS_VH
`define ECP_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets on the AXI4-Lite slave
// ----------------------------------------------------------------
`define ECP_OFF_ARRAY_CFG 6'h00
`define ECP_OFF_DIV_HIGH 6'h04
`define ECP_OFF_DIV_LOW 6'h08
`define ECP_OFF_NV_CFG 6'h0c
`define ECP_OFF_NV_DIV_HIGH 6'h10
`define ECP_OFF_NV_DIV_LOW 6'h14
`define ECP_OFF_SYS_CFG 6'h18
`define ECP_OFF_PE_REQ 6'h1c
`define ECP_OFF_PE_STATUS 6'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ECP_CFG_PERM_BIT 4
`define ECP_CFG_BP_HI 3
`define ECP_CFG_BP_LO 0
`define ECP_DIVH_SECURE_BIT 7
`define ECP_DIVH_VALUE_HI 2
`define ECP_REQ_ADDR_HI 15
`define ECP_REQ_DATA_LO 16
`define ECP_REQ_DATA_HI 23
`define ECP_REQ_MODE_LO 24
`define ECP_REQ_MODE_HI 25
`define ECP_SYS_CLKSEL_BIT 0

// ----------------------------------------------------------------
// Program/erase modes
// ----------------------------------------------------------------
`define ECP_MODE_PROGRAM 2'h0
`define ECP_MODE_BYTE_ERASE 2'h1
`define ECP_MODE_BLOCK_ERASE 2'h2
`define ECP_MODE_BULK_ERASE 2'h3

// ----------------------------------------------------------------
// Address map of the array and the nonvolatile cells
// ----------------------------------------------------------------
`define ECP_ARRAY_BASE_HI 7'h04
`define ECP_SECURE_LO 16'h08f0
`define ECP_SECURE_HI 16'h08ff
`define ECP_ADDR_NV_DIV_HIGH 16'hfe10
`define ECP_ADDR_NV_DIV_LOW 16'hfe11
`define ECP_ADDR_NV_CFG 16'hfe1c

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define ECP_ERASED_BYTE 8'hff
`define ECP_DIVH_UNIMPL_MASK 8'h87
`define ECP_CFG_IMPL_MASK 8'h1f
`define ECP_TIMEBASE_US 35
`define ECP_RESP_OKAY 2'h0
`define ECP_RESP_SLVERR 2'h2

`endif

// File: hdl/ecp_guard.v
// Program/erase permission check for one request
`timescale 1ns/1ps
`default_nettype none
`include "ecp_defs.vh"

module ecp_guard (
  // Request
  input wire [15:0] addr,
  input wire [1:0] mode,
  // Configuration in force
  input wire [3:0] block_protect_bits,
  input wire perm_armed,
  input wire div_secure,
  // Verdict
  output reg allowed
);

  wire in_array;
  wire in_secure;
  wire blk_prot;
  wire single;

  assign in_array = (addr[15:9] == `ECP_ARRAY_BASE_HI);
  assign in_secure = (addr >= `ECP_SECURE_LO) && (addr <= `ECP_SECURE_HI);
  assign blk_prot = block_protect_bits[addr[8:7]];
  assign single = (mode == `ECP_MODE_PROGRAM) || (mode == `ECP_MODE_BYTE_ERASE);

  // Unknown addresses are refused so nothing downstream moves
  always @*
  begin
    allowed = 1'b0;
    if (in_array)
    begin
      if (mode == `ECP_MODE_BULK_ERASE)
        allowed = ~perm_armed & ~(|block_protect_bits);
      else if (blk_prot)
        allowed = 1'b0;
      else if (perm_armed && (in_secure || !single))
        allowed = 1'b0;
      else
        allowed = 1'b1;
    end
    else if (addr == `ECP_ADDR_NV_CFG)
      allowed = single & ~perm_armed;
    else if ((addr == `ECP_ADDR_NV_DIV_HIGH) || (addr == `ECP_ADDR_NV_DIV_LOW))
      allowed = single & ~div_secure;
  end

endmodule
`default_nettype wire

// File: hdl/ecp_timebase.v
// Program/erase timebase divider
`timescale 1ns/1ps
`default_nettype none

module ecp_timebase #(
  parameter WIDTH = 16
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Reference selection
  input wire clk_select,
  input wire xtal_tick,
  input wire [WIDTH-1:0] divider,
  // Timebase enable out
  output reg tick
);

  reg [WIDTH-1:0] count_reg;
  wire ref_tick;

  // Crystal ticks or every bus cycle
  assign ref_tick = clk_select ? 1'b1 : xtal_tick;

  // Count reference ticks up to the divider; zero divider stops the timebase
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_reg <= {WIDTH{1'b0}};
      tick <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (divider == {WIDTH{1'b0}})
        count_reg <= {WIDTH{1'b0}};
      else if (ref_tick)
      begin
        if (count_reg >= divider - {{(WIDTH-1){1'b0}}, 1'b1})
        begin
          count_reg <= {WIDTH{1'b0}};
          tick <= 1'b1;
        end
        else
          count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule
`default_nettype wire

// File: hdl/ecp_top.v
// EEPROM configuration loading and program/erase protection with AXI4-Lite registers
// Operation
// - Each reset copies config cell and both divider cells into volatile copies.
// - Configuration in force comes from the volatile copies; the config cell itself can also arm permanent protection.
// - Timebase divides crystal or bus clock by the 11-bit divider.
// - Programming permanent-protect bit to 0 secures 08F0 to 08FF.
// - Armed: secured bytes never programmed or erased, still readable.
// - Armed: program and erase of the config cell refused forever.
// - Armed: block and bulk erase refused everywhere.
// - Armed: single-byte operations allowed outside secure area if unprotected.
// - Armed: config cell functions stay frozen.
// - Four 128-byte blocks, each protected while its bit is set.
// - Protect bits 0..3 cover 0800, 0880, 0900, 0980 blocks.
// - New protect bits act after reset or a read of the config cell.
// - Divider-secure bit 0 reloads 0 and freezes both divider cells.
// - While divider secure, writes to divider copies are ignored.
// - Erased cells read 1; programming drives 0.
`timescale 1ns/1ps
`default_nettype none
`include "ecp_defs.vh"

module ecp_top #(
  parameter DIV_WIDTH = 16
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Factory blank strobe for the nonvolatile cells, active low
  input wire nv_blank_n,
  // Crystal reference tick, one cycle per crystal period
  input wire crystal_reference_clock,
  // AXI4-Lite write address
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Granted request to the array sequencer
  output reg pe_go,
  output reg [15:0] pe_addr,
  output reg [7:0] pe_data,
  output reg [1:0] pe_mode,
  // Program/erase timebase enable
  output wire pe_tick
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Nonvolatile cells: no bus reset, only the factory blank strobe
  reg [7:0] eeprom_config_nv_cell;
  reg [7:0] divider_nv_high;
  reg [7:0] divider_nv_low;
  // Volatile copies
  reg [7:0] array_config_copy;
  reg [7:0] divider_high_copy;
  reg [7:0] divider_low_copy;
  reg [7:0] system_config_two;
  reg last_allowed_reg;
  reg last_refused_reg;
  // Bus capture
  reg aw_have_reg;
  reg w_have_reg;
  reg [5:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;

  wire [DIV_WIDTH-1:0] timebase_divider_value;
  wire perm_armed;
  wire div_secure;
  wire do_write;
  wire rd_take;
  wire wr_lane0;
  wire req_write;
  wire [15:0] req_addr;
  wire [1:0] req_mode;
  wire [7:0] req_data;
  wire req_allowed;
  wire nv_read;

  // ----------------------------------------------------------------
  // Configuration in force
  // ----------------------------------------------------------------
  // Either the copy or a freshly programmed cell arms protection at once
  assign perm_armed = ~array_config_copy[`ECP_CFG_PERM_BIT]
    | ~eeprom_config_nv_cell[`ECP_CFG_PERM_BIT];
  assign div_secure = ~divider_high_copy[`ECP_DIVH_SECURE_BIT];
  // Unimplemented upper divider bits read as zero
  assign timebase_divider_value = {{(DIV_WIDTH-`ECP_DIVH_VALUE_HI-9){1'b0}},
    divider_high_copy[`ECP_DIVH_VALUE_HI:0], divider_low_copy};

  // ----------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------
  // One write and one read in flight; new addresses wait for the response
  assign s_axi_awready = ~aw_have_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_have_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  assign rd_take = s_axi_arvalid & s_axi_arready;
  assign wr_lane0 = do_write & w_strb_reg[0];

  // Request fields from the data word
  assign req_write = wr_lane0 && (aw_addr_reg == `ECP_OFF_PE_REQ);
  assign req_addr = w_data_reg[`ECP_REQ_ADDR_HI:0];
  assign req_data = w_data_reg[`ECP_REQ_DATA_HI:`ECP_REQ_DATA_LO];
  assign req_mode = w_data_reg[`ECP_REQ_MODE_HI:`ECP_REQ_MODE_LO];
  assign nv_read = rd_take && (s_axi_araddr == `ECP_OFF_NV_CFG);

  // Capture write address and data in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 6'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ECP_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr_reg)
          `ECP_OFF_DIV_HIGH, `ECP_OFF_DIV_LOW, `ECP_OFF_SYS_CFG, `ECP_OFF_PE_REQ,
          `ECP_OFF_ARRAY_CFG, `ECP_OFF_NV_CFG, `ECP_OFF_NV_DIV_HIGH,
          `ECP_OFF_NV_DIV_LOW, `ECP_OFF_PE_STATUS:
            s_axi_bresp <= `ECP_RESP_OKAY;
          default:
            s_axi_bresp <= `ECP_RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  // Read data registered one cycle after the address is taken
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ECP_RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `ECP_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      case (s_axi_araddr)
        `ECP_OFF_ARRAY_CFG:
          s_axi_rdata[7:0] <= array_config_copy;
        `ECP_OFF_DIV_HIGH:
          s_axi_rdata[7:0] <= divider_high_copy;
        `ECP_OFF_DIV_LOW:
          s_axi_rdata[7:0] <= divider_low_copy;
        `ECP_OFF_NV_CFG:
          s_axi_rdata[7:0] <= eeprom_config_nv_cell;
        `ECP_OFF_NV_DIV_HIGH:
          s_axi_rdata[7:0] <= divider_nv_high;
        `ECP_OFF_NV_DIV_LOW:
          s_axi_rdata[7:0] <= divider_nv_low;
        `ECP_OFF_SYS_CFG:
          s_axi_rdata[7:0] <= system_config_two;
        `ECP_OFF_PE_STATUS:
          s_axi_rdata[1:0] <= {last_refused_reg, last_allowed_reg};
        `ECP_OFF_PE_REQ:
          s_axi_rdata <= {6'h00, pe_mode, pe_data, pe_addr};
        default:
          s_axi_rresp <= `ECP_RESP_SLVERR;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Permission check
  // ----------------------------------------------------------------
  ecp_guard u_guard (
    .addr(req_addr),
    .mode(req_mode),
    .block_protect_bits(array_config_copy[`ECP_CFG_BP_HI:`ECP_CFG_BP_LO]),
    .perm_armed(perm_armed),
    .div_secure(div_secure),
    .allowed(req_allowed)
  );

  // ----------------------------------------------------------------
  // Nonvolatile cells
  // ----------------------------------------------------------------
  // Program clears bits only, erase returns to all ones; refused requests never land
  always @(posedge aclk)
  begin
    if (!nv_blank_n)
    begin
      eeprom_config_nv_cell <= `ECP_ERASED_BYTE;
      divider_nv_high <= `ECP_ERASED_BYTE;
      divider_nv_low <= `ECP_ERASED_BYTE;
    end
    else if (req_write && req_allowed)
    begin
      case (req_addr)
        `ECP_ADDR_NV_CFG:
          eeprom_config_nv_cell <= (req_mode == `ECP_MODE_PROGRAM)
            ? (eeprom_config_nv_cell & req_data) : `ECP_ERASED_BYTE;
        `ECP_ADDR_NV_DIV_HIGH:
          divider_nv_high <= (req_mode == `ECP_MODE_PROGRAM)
            ? (divider_nv_high & req_data) : `ECP_ERASED_BYTE;
        `ECP_ADDR_NV_DIV_LOW:
          divider_nv_low <= (req_mode == `ECP_MODE_PROGRAM)
            ? (divider_nv_low & req_data) : `ECP_ERASED_BYTE;
        default:
          eeprom_config_nv_cell <= eeprom_config_nv_cell;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Volatile copies
  // ----------------------------------------------------------------
  // Reset loads the cells; a read of the config cell refreshes the protect copy
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      array_config_copy <= eeprom_config_nv_cell & `ECP_CFG_IMPL_MASK;
      divider_high_copy <= divider_nv_high & `ECP_DIVH_UNIMPL_MASK;
      divider_low_copy <= divider_nv_low;
      system_config_two <= 8'h00;
    end
    else
    begin
      if (nv_read)
        array_config_copy <= eeprom_config_nv_cell & `ECP_CFG_IMPL_MASK;
      // Secure divider copies hold their reset values against software
      if (wr_lane0 && (aw_addr_reg == `ECP_OFF_DIV_HIGH) && !div_secure)
        divider_high_copy <= w_data_reg[7:0] & `ECP_DIVH_UNIMPL_MASK;
      if (wr_lane0 && (aw_addr_reg == `ECP_OFF_DIV_LOW) && !div_secure)
        divider_low_copy <= w_data_reg[7:0];
      if (wr_lane0 && (aw_addr_reg == `ECP_OFF_SYS_CFG))
        system_config_two <= w_data_reg[7:0] & 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Request grant to the array sequencer
  // ----------------------------------------------------------------
  // Only granted requests reach the sequencer; status keeps the last verdict
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pe_go <= 1'b0;
      pe_addr <= 16'h0000;
      pe_data <= 8'h00;
      pe_mode <= `ECP_MODE_PROGRAM;
      last_allowed_reg <= 1'b0;
      last_refused_reg <= 1'b0;
    end
    else
    begin
      pe_go <= req_write & req_allowed;
      if (req_write)
      begin
        last_allowed_reg <= req_allowed;
        last_refused_reg <= ~req_allowed;
        if (req_allowed)
        begin
          pe_addr <= req_addr;
          pe_data <= req_data;
          pe_mode <= req_mode;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  ecp_timebase #(
    .WIDTH(DIV_WIDTH)
  ) u_timebase (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_select(system_config_two[`ECP_SYS_CLKSEL_BIT]),
    .xtal_tick(crystal_reference_clock),
    .divider(timebase_divider_value),
    .tick(pe_tick)
  );

endmodule
`default_nettype wire

// File: verification/ecp_checker_assertions.sv
// Concurrent checks on the ports of the EEPROM configuration and protection block
`timescale 1ns/1ps
`default_nettype none
`include "ecp_defs.vh"

// ------------------------------------------------------------
// Checker
// ------------------------------------------------------------
module ecp_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Granted request
  input wire logic pe_go,
  input wire logic [15:0] pe_addr,
  input wire logic [1:0] pe_mode
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Address and data of a write taken together, a read address taken
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  // Answers stand until the master takes them
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");

  // Answer latency as handed over
  property p_w_lat;
    s_wr_taken |-> ##2 s_axi_bvalid;
  endproperty
  a_w_lat: assert property (p_w_lat) else $error("write response late");
  property p_r_lat;
    s_rd_taken |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read data late");

  // No new write accepted while a write response is pending, no new read while read data is pending
  property p_busy;
    (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) and (s_axi_rvalid |-> !s_axi_arready);
  endproperty
  a_busy: assert property (p_busy) else $error("request taken while answer pending");

  // A grant is one pulse, tied to the write that carried it
  property p_go_cause;
    pe_go |-> $rose(s_axi_bvalid) ##1 !pe_go;
  endproperty
  a_go_cause: assert property (p_go_cause) else $error("grant without its write");

  // Block and bulk erase are only ever granted inside the array
  property p_go_erase;
    pe_go && pe_mode[1] |-> pe_addr[15:9] == `ECP_ARRAY_BASE_HI;
  endproperty
  a_go_erase: assert property (p_go_erase) else $error("wide erase outside array");

  // Outside the array only the three cells may be granted
  property p_go_cell;
    pe_go && pe_addr[15:9] != `ECP_ARRAY_BASE_HI |->
      pe_addr == `ECP_ADDR_NV_CFG || pe_addr == `ECP_ADDR_NV_DIV_HIGH ||
      pe_addr == `ECP_ADDR_NV_DIV_LOW;
  endproperty
  a_go_cell: assert property (p_go_cell) else $error("grant to unknown target");
endmodule

bind ecp_top ecp_checker u_checker (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pe_go, .pe_addr, .pe_mode);
`default_nettype wire

// File: verification/ecp_testbench.sv
// Self-checking bench for the EEPROM configuration and protection block
`timescale 1ns/1ps
`default_nettype none
`include "ecp_defs.vh"

module testbench;
  // ------------------------------------------------------------
  // Signals and design
  // ------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic nv_blank_n = 1'b0;
  logic crystal_reference_clock = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00;
  logic [5:0] s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  // Master always ready for answers, so each is taken at the edge it first shows
  logic s_axi_bready = 1'b1;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b1;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pe_go, pe_tick;
  wire [1:0] s_axi_bresp, s_axi_rresp, pe_mode;
  wire [31:0] s_axi_rdata;
  wire [15:0] pe_addr;
  wire [7:0] pe_data;
  int miscompares = 0;
  int samples_checked = 0;
  int go_cnt = 0;
  int xcnt = 0;
  logic [25:0] last_go = 26'h0;
  logic [31:0] prev = 32'h1f;

  // 25 MHz bus clock
  always #20 aclk = ~aclk;

  // Crystal tick every third cycle, so the two references give different periods
  always @(posedge aclk)
  begin
    xcnt <= (xcnt == 2) ? 0 : xcnt + 1;
    crystal_reference_clock <= (xcnt == 2);
  end

  // Grant monitor
  always @(posedge aclk)
  begin
    if (pe_go === 1'b1)
    begin
      go_cnt <= go_cnt + 1;
      last_go <= {pe_mode, pe_data, pe_addr};
    end
  end

  ecp_top u_dut (.aclk, .aresetn, .nv_blank_n, .crystal_reference_clock, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pe_go, .pe_addr, .pe_data,
    .pe_mode, .pe_tick);

  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic close_out();
    if (miscompares == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Response taken at the edge where bvalid is sampled high; a lost answer counts
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    chk("bvalid", 34'h1, {33'h0, s_axi_bvalid});
    chk($sformatf("bresp %h", a), {32'h0, er}, {32'h0, s_axi_bresp});
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    chk("rvalid", 34'h1, {33'h0, s_axi_rvalid});
    chk($sformatf("read %h", a), {er, ed}, {s_axi_rresp, s_axi_rdata});
  endtask

  // One program/erase request, its grant and its status
  task automatic req(input logic [15:0] a, input logic [7:0] d, input logic [1:0] m,
    input logic ok);
    int g;
    g = go_cnt;
    wr(`ECP_OFF_PE_REQ, {6'h0, m, d, a});
    repeat (2) @(posedge aclk);
    chk($sformatf("grants %h", a), {33'h0, ok}, 34'(go_cnt - g));
    if (ok) chk("granted", {m, d, a}, last_go);
    rd(`ECP_OFF_PE_STATUS, ok ? 32'h1 : 32'h2);
  endtask

  // Cycles between two timebase pulses
  task automatic gap(input int e);
    int n;
    n = 0;
    do @(posedge aclk); while (pe_tick !== 1'b1 && n++ < 1000);
    n = 0;
    do @(posedge aclk); while (pe_tick !== 1'b1 && n++ < 1000);
    chk("tick gap", e, 34'(n + 1));
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    do_reset();
    nv_blank_n <= 1'b1;
    rd(`ECP_OFF_ARRAY_CFG, 32'h1f);
    rd(`ECP_OFF_DIV_HIGH, 32'h87);
    rd(`ECP_OFF_DIV_LOW, 32'hff);
    rd(`ECP_OFF_NV_CFG, 32'hff);
    rd(6'h24, 32'h0, `ECP_RESP_SLVERR);
    wr(6'h24, 32'h0, `ECP_RESP_SLVERR);
    wr(`ECP_OFF_ARRAY_CFG, 32'h0);
    rd(`ECP_OFF_ARRAY_CFG, 32'h1f);
    // Divider passes through 0 so the counter never runs past the new value
    wr(`ECP_OFF_DIV_HIGH, 32'h80);
    wr(`ECP_OFF_DIV_LOW, 32'h00);
    wr(`ECP_OFF_DIV_LOW, 32'h05);
    rd(`ECP_OFF_DIV_HIGH, 32'h80);
    rd(`ECP_OFF_DIV_LOW, 32'h05);
    gap(15);
    wr(`ECP_OFF_SYS_CFG, 32'h1);
    gap(5);
    // Rounded 35 us divider for the 25 MHz bus clock is 875 cycles
    wr(`ECP_OFF_DIV_HIGH, 32'h83);
    wr(`ECP_OFF_DIV_LOW, 32'h6b);
    gap(875);
    // One protected-free block at a time, refreshed by reading the cell
    for (int i = 0; i < 4; i++)
    begin
      req(`ECP_ADDR_NV_CFG, 8'h00, `ECP_MODE_BYTE_ERASE, 1'b1);
      req(`ECP_ADDR_NV_CFG, 8'hff ^ (8'h01 << i), `ECP_MODE_PROGRAM, 1'b1);
      rd(`ECP_OFF_ARRAY_CFG, prev);
      rd(`ECP_OFF_NV_CFG, 32'hff ^ (32'h1 << i));
      prev = 32'h1f ^ (32'h1 << i);
      rd(`ECP_OFF_ARRAY_CFG, prev);
      for (int j = 0; j < 4; j++)
        req(16'h087f + 16'(j) * 16'h0080, 8'h5a, `ECP_MODE_PROGRAM, i == j);
    end
    req(`ECP_ADDR_NV_CFG, 8'h00, `ECP_MODE_BYTE_ERASE, 1'b1);
    req(`ECP_ADDR_NV_CFG, 8'hf0, `ECP_MODE_PROGRAM, 1'b1);
    rd(`ECP_OFF_NV_CFG, 32'hf0);
    for (int k = 0; k < 4; k++)
      req(16'h0900, 8'h3c, 2'(k), 1'b1);
    // Arm permanent protection, then probe every refusal it brings
    req(`ECP_ADDR_NV_CFG, 8'hef, `ECP_MODE_PROGRAM, 1'b1);
    req(16'h08f0, 8'h00, `ECP_MODE_PROGRAM, 1'b0);
    req(16'h08ff, 8'h00, `ECP_MODE_BYTE_ERASE, 1'b0);
    req(16'h08ef, 8'h00, `ECP_MODE_PROGRAM, 1'b1);
    req(16'h0900, 8'h00, `ECP_MODE_BYTE_ERASE, 1'b1);
    req(16'h0900, 8'h00, `ECP_MODE_BLOCK_ERASE, 1'b0);
    req(16'h0800, 8'h00, `ECP_MODE_BULK_ERASE, 1'b0);
    req(`ECP_ADDR_NV_CFG, 8'h00, `ECP_MODE_BYTE_ERASE, 1'b0);
    req(`ECP_ADDR_NV_CFG, 8'h00, `ECP_MODE_PROGRAM, 1'b0);
    req(16'h0a00, 8'h00, `ECP_MODE_PROGRAM, 1'b0);
    // Refused requests leave the last granted one in place
    rd(`ECP_OFF_PE_REQ, 32'h01000900);
    rd(`ECP_OFF_ARRAY_CFG, 32'h10);
    rd(`ECP_OFF_NV_CFG, 32'he0);
    rd(`ECP_OFF_ARRAY_CFG, 32'h00);
    // Secure the divider, then reset without blanking the cells
    req(`ECP_ADDR_NV_DIV_HIGH, 8'h7f, `ECP_MODE_PROGRAM, 1'b1);
    rd(`ECP_OFF_NV_DIV_HIGH, 32'h7f);
    do_reset();
    rd(`ECP_OFF_DIV_HIGH, 32'h07);
    rd(`ECP_OFF_ARRAY_CFG, 32'h00);
    wr(`ECP_OFF_DIV_LOW, 32'h33);
    wr(`ECP_OFF_DIV_HIGH, 32'h80);
    rd(`ECP_OFF_DIV_LOW, 32'hff);
    rd(`ECP_OFF_DIV_HIGH, 32'h07);
    req(`ECP_ADDR_NV_DIV_LOW, 8'h00, `ECP_MODE_PROGRAM, 1'b0);
    req(`ECP_ADDR_NV_DIV_HIGH, 8'h00, `ECP_MODE_BYTE_ERASE, 1'b0);
    close_out();
  end

  // Watchdog: the sequence needs about 2200 cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
